// [dei_buffer_changed_flag_core.sv]
`timescale 1ns/100ps
// diagnostic event logging, return flags and diagnostic interrupt of two channels
module dei_buffer_changed_flag_core (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] buffer_changed_flag_pin,
  input wire logic [5:0] oper_err,
  input wire logic [1:0] md_err,
  input wire logic job_err_valid,
  input wire dei_pkg::dei_job_err_t job_err,
  input wire logic wr_job_done,
  input wire logic wr_job_chan,
  input wire logic wr_job_err,
  input wire logic pos_busy,
  input wire logic [1:0] start_cmd,
  input wire logic [1:0] dir_p_cmd,
  input wire logic [1:0] dir_m_cmd,
  input wire logic [1:0] beyond_p,
  input wire logic [1:0] beyond_m,
  output logic [1:0] start_ok,
  output logic [1:0] dir_p_ok,
  output logic [1:0] dir_m_ok,
  output logic [1:0] pos_abort,
  output logic [1:0] sync_clear,
  output logic group_fault_indicator,
  output logic channel_one_fault_indicator,
  output logic channel_two_fault_indicator,
  output logic [1:0] buffer_changed_flag,
  output logic [1:0] data_error_flag,
  output logic [1:0] travel_start_error_flag,
  output logic buffer_changed_flag_int,
  output logic [7:0] buffer_changed_flag_ev_class,
  output logic module_fault_bit
);
  // wrap a 0..26 sum into a ring slot
  function automatic logic [3:0] dei_mod9(input logic [4:0] v);
    if (v < 5'd9) begin
      return v[3:0];
    end else if (v < 5'd18) begin
      return 4'(v - 5'd9);
    end
    return 4'(v - 5'd18);
  endfunction : dei_mod9

  // lowest waiting source goes first
  function automatic logic [3:0] dei_first(input logic [15:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction : dei_first

  // entry for an asynchronous source slot
  function automatic dei_pkg::dei_entry_t dei_src_entry(input logic [3:0] idx);
    dei_pkg::dei_entry_t e;
    e = '0;
    e.entering = 1'b1;
    e.external = (int'(idx[2:0]) <= dei_pkg::DEI_K_PIN_LAST);
    e.internal = ~e.external;
    if (e.external) begin
      e.eclass = dei_pkg::DEI_CLS_BUFFER_CHANGED_FLAG;
    end else if (int'(idx[2:0]) == dei_pkg::DEI_K_MD) begin
      e.eclass = dei_pkg::DEI_CLS_MDAT;
    end else begin
      e.eclass = dei_pkg::DEI_CLS_OPER;
    end
    e.number = {5'h00, idx[2:0]} + 8'h01; // slot number plus one
    e.chan = idx[3];
    return e;
  endfunction : dei_src_entry

  logic [7:0] pin_lvl; // synchronized diagnostic pins
  logic [15:0] pend_q, pend_d; // pending errors, 8 slots per channel
  logic [15:0] prev_q, prev_d; // pending one cycle earlier
  logic run_prev_q, run_prev_d;
  logic [15:0] rise, fall;
  logic any_pend;
  // bus registers
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;
  logic [7:0] ctrl_q, ctrl_d;
  logic acc, wr_ctrl, rd_entry, is_entry;
  logic [11:0] eoff;
  logic [3:0] ei;
  // ring
  dei_pkg::dei_entry_t mem_q [dei_pkg::DEI_DEPTH];
  dei_pkg::dei_entry_t mem_d [dei_pkg::DEI_DEPTH];
  logic [3:0] wr_q, wr_d, cnt_q, cnt_d, wr_b, cnt_b;
  logic [15:0] req_q, req_d; // entering errors still to log
  logic app;
  dei_pkg::dei_entry_t ent;
  // flags
  logic [1:0] chg_q, chg_d, derr_q, derr_d, terr_q, terr_d;
  // interrupt and indicators
  logic int_q, int_d, mdf_q, mdf_d, gf_q, gf_d, enter, leave, runr;
  logic [7:0] cls_q, cls_d;
  logic [1:0] chf_q, chf_d, abort_q, abort_d, sclr_q, sclr_d;
  logic [1:0] st_q, st_d, dp_q, dp_d, dm_q, dm_d;

  // pins are asynchronous, all other inputs share this clock
  dei_sync #(.W(8)) u_pin_sync (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .async_in(buffer_changed_flag_pin),
    .level_q(pin_lvl)
  );

  // pending vector, machine data only counts with system block parameters
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      pend_d[c*8 +: 8] = {md_err[c] & ctrl_q[dei_pkg::DEI_C_SYSPB],
                          oper_err[c*3 +: 3], pin_lvl[c*4 +: 4]};
    end
    prev_d = pend_q;
    run_prev_d = ctrl_q[dei_pkg::DEI_C_RUN];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pend_q <= '0;
      prev_q <= '0;
      run_prev_q <= 1'b0;
    end else if (ce) begin
      pend_q <= pend_d;
      prev_q <= prev_d;
      run_prev_q <= run_prev_d;
    end
  end

  assign rise = pend_q & ~prev_q;
  assign fall = ~pend_q & prev_q;
  assign any_pend = |pend_q;

  // apb decode, one wait state on every access
  assign acc = psel & penable & pready_q;
  assign wr_ctrl = acc & pwrite & (paddr == dei_pkg::DEI_OFF_CTRL);
  assign eoff = paddr - dei_pkg::DEI_OFF_ENTRY0;
  assign ei = eoff[5:2];
  assign is_entry = (paddr >= dei_pkg::DEI_OFF_ENTRY0) && (eoff[11:2] < 10'd9) &&
                    (paddr[1:0] == 2'b00);
  assign rd_entry = acc & ~pwrite & is_entry;

  // read mux, unmapped or misaligned answers slverr with zero data
  always_comb begin
    pready_d = psel & penable & ~pready_q;
    prdata_d = '0;
    pslverr_d = 1'b0;
    ctrl_d = ctrl_q;
    if (is_entry) begin
      if (ei < cnt_q) begin
        prdata_d = mem_q[dei_mod9({1'b0, wr_q} + 5'd9 - {1'b0, cnt_q} + {1'b0, ei})];
      end
    end else if (paddr == dei_pkg::DEI_OFF_CTRL) begin
      prdata_d[7:0] = ctrl_q;
    end else if (paddr == dei_pkg::DEI_OFF_STAT) begin
      prdata_d[dei_pkg::DEI_S_CHG +: 2] = chg_q;
      prdata_d[dei_pkg::DEI_S_DERR +: 2] = derr_q;
      prdata_d[dei_pkg::DEI_S_TERR +: 2] = terr_q;
      prdata_d[dei_pkg::DEI_S_GF] = gf_q;
      prdata_d[dei_pkg::DEI_S_MDF] = mdf_q;
      prdata_d[dei_pkg::DEI_S_CNT +: 4] = cnt_q;
      prdata_d[dei_pkg::DEI_S_CLS +: 8] = cls_q;
    end else if (paddr == dei_pkg::DEI_OFF_PEND) begin
      prdata_d[15:0] = pend_q;
    end else begin
      pslverr_d = pready_d;
    end
    if (~pready_d) begin
      prdata_d = '0;
    end
    if (wr_ctrl) begin
      ctrl_d = pwdata[7:0] & dei_pkg::DEI_CTRL_WMASK;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
      ctrl_q <= dei_pkg::DEI_CTRL_RST;
    end else if (ce) begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
      ctrl_q <= ctrl_d;
    end
  end

  // logging: a job error cannot wait, so waiting sources yield to it
  always_comb begin
    req_d = req_q;
    app = 1'b0;
    ent = '0;
    if (job_err_valid) begin
      app = 1'b1;
      ent.entering = 1'b1;
      ent.internal = 1'b1;
      ent.eclass = job_err.eclass;
      ent.number = job_err.number;
      ent.chan = job_err.chan;
      ent.idim = job_err.idim;
    end else if (|req_q) begin
      app = 1'b1;
      ent = dei_src_entry(dei_first(req_q));
      req_d[dei_first(req_q)] = 1'b0;
    end
    req_d = req_d | rise;
    // delete only when no positioning is running
    if (wr_ctrl && pwdata[dei_pkg::DEI_C_BCLR] && !pos_busy) begin
      wr_b = 4'h0;
      cnt_b = 4'h0;
    end else begin
      wr_b = wr_q;
      cnt_b = cnt_q;
    end
    mem_d = mem_q;
    wr_d = wr_b;
    cnt_d = cnt_b;
    if (app) begin
      mem_d[wr_b] = ent;
      wr_d = dei_mod9({1'b0, wr_b} + 5'd1);
      cnt_d = (cnt_b == 4'd9) ? cnt_b : cnt_b + 4'd1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      req_q <= '0;
      wr_q <= 4'h0;
      cnt_q <= 4'h0;
      for (int i = 0; i < dei_pkg::DEI_DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else if (ce) begin
      req_q <= req_d;
      wr_q <= wr_d;
      cnt_q <= cnt_d;
      mem_q <= mem_d;
    end
  end

  // return flags, a set in the cycle of a clear wins
  always_comb begin
    chg_d = (chg_q & ~{2{rd_entry}});
    if (app) begin
      chg_d = chg_d | ctrl_q[dei_pkg::DEI_C_INUSE +: 2];
    end
    derr_d = derr_q;
    terr_d = terr_q;
    for (int c = 0; c < 2; c++) begin
      // write jobs run regardless of pending errors
      if (wr_job_done && (wr_job_chan == c[0])) begin
        derr_d[c] = wr_job_err;
      end
      if (wr_ctrl && pwdata[dei_pkg::DEI_C_ACK + c]) begin
        terr_d[c] = 1'b0;
      end
      if (job_err_valid && job_err.travel && (job_err.chan == c[0])) begin
        terr_d[c] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      chg_q <= '0;
      derr_q <= '0;
      terr_q <= '0;
    end else if (ce) begin
      chg_q <= chg_d;
      derr_q <= derr_d;
      terr_q <= terr_d;
    end
  end

  // interrupt decisions; the buffer is never touched by a leaving event
  assign runr = ctrl_q[dei_pkg::DEI_C_RUN] & ~run_prev_q;
  assign enter = ctrl_q[dei_pkg::DEI_C_RUN] & ctrl_q[dei_pkg::DEI_C_IRQEN] &
                 ((|rise) | ((|fall) & any_pend) | (runr & any_pend));
  assign leave = ctrl_q[dei_pkg::DEI_C_RUN] & run_prev_q &
                 ctrl_q[dei_pkg::DEI_C_IRQEN] & (|fall) & ~any_pend;

  always_comb begin
    int_d = enter | leave;
    cls_d = cls_q;
    mdf_d = mdf_q;
    if (enter) begin
      cls_d = dei_pkg::DEI_EV_ENTER;
    end else if (leave) begin
      cls_d = dei_pkg::DEI_EV_LEAVE;
    end
    if (enter || leave) begin
      mdf_d = any_pend;
    end
    gf_d = any_pend;
    for (int c = 0; c < 2; c++) begin
      chf_d[c] = |pend_q[c*8 +: 8];
      abort_d[c] = |rise[c*8 +: 8];
      sclr_d[c] = |rise[c*8 +: dei_pkg::DEI_K_SYNC_LAST + 1];
    end
  end

  // motion gating; an operating-only fault still lets the axis jog home
  always_comb begin
    logic blk;
    logic op_only;
    blk = 1'b0;
    op_only = 1'b0;
    for (int c = 0; c < 2; c++) begin
      blk = |pend_q[c*8 +: 8];
      op_only = (|pend_q[c*8 + dei_pkg::DEI_K_OP_FIRST +: 3]) &&
                !(|pend_q[c*8 +: dei_pkg::DEI_K_PIN_LAST + 1]) &&
                !pend_q[c*8 + dei_pkg::DEI_K_MD];
      st_d[c] = start_cmd[c] & ~blk;
      dp_d[c] = dir_p_cmd[c] & (~blk | (op_only & beyond_m[c]));
      dm_d[c] = dir_m_cmd[c] & (~blk | (op_only & beyond_p[c]));
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      int_q <= 1'b0;
      cls_q <= '0;
      mdf_q <= 1'b0;
      gf_q <= 1'b0;
      chf_q <= '0;
      abort_q <= '0;
      sclr_q <= '0;
      st_q <= '0;
      dp_q <= '0;
      dm_q <= '0;
    end else if (ce) begin
      int_q <= int_d;
      cls_q <= cls_d;
      mdf_q <= mdf_d;
      gf_q <= gf_d;
      chf_q <= chf_d;
      abort_q <= abort_d;
      sclr_q <= sclr_d;
      st_q <= st_d;
      dp_q <= dp_d;
      dm_q <= dm_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign start_ok = st_q;
  assign dir_p_ok = dp_q;
  assign dir_m_ok = dm_q;
  assign pos_abort = abort_q;
  assign sync_clear = sclr_q;
  assign group_fault_indicator = gf_q;
  assign channel_one_fault_indicator = chf_q[0];
  assign channel_two_fault_indicator = chf_q[1];
  assign buffer_changed_flag = chg_q;
  assign data_error_flag = derr_q;
  assign travel_start_error_flag = terr_q;
  assign buffer_changed_flag_int = int_q;
  assign buffer_changed_flag_ev_class = cls_q;
  assign module_fault_bit = mdf_q;

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_setup;
    ce && psel && !penable;
  endsequence
  sequence s_wait;
    ce && psel && penable && !pready;
  endsequence

  a_apb_wait_state: assert property (s_setup ##1 s_wait |=> pready && psel)
    else $error("no answer after one wait cycle");
  a_apb_one_pulse: assert property ((ce && pready) |=> !pready)
    else $error("pready held longer than one cycle");
  a_ring_full_hold: assert property ((ce && app && cnt_q == 4'd9 &&
    !wr_ctrl) |=> cnt_q == 4'd9) else $error("full ring count moved");
  a_ring_bound: assert property (cnt_q <= 4'd9)
    else $error("ring count above nine");
  a_changed_set: assert property ((ce && app && ctrl_q[dei_pkg::DEI_C_INUSE]) |=>
    buffer_changed_flag[0]) else $error("changed flag not set on logging");
  a_changed_clear: assert property ((ce && rd_entry && !app) |=>
    buffer_changed_flag == 2'b00) else $error("changed flag not cleared on read");
  a_stop_quiet: assert property ((ce && !ctrl_q[dei_pkg::DEI_C_RUN]) |=>
    !buffer_changed_flag_int) else $error("interrupt while host stopped");
  a_leave_last: assert property ((buffer_changed_flag_int &&
    buffer_changed_flag_ev_class == dei_pkg::DEI_EV_LEAVE) |-> !group_fault_indicator && !module_fault_bit)
    else $error("leaving with errors left");
  a_start_block: assert property (start_ok[0] |-> !channel_one_fault_indicator)
    else $error("start passed during fault");
  // channel two carries the travel start fault in the tests, so watch that one
  a_travel_hold: assert property ((ce && travel_start_error_flag[1] &&
    !(wr_ctrl && pwdata[dei_pkg::DEI_C_ACK + 1])) |=> travel_start_error_flag[1])
    else $error("travel flag lost");
  // travel range exceeded is both an abort and a synchronization loss
  a_abort_rise: assert property ((ce && rise[dei_pkg::DEI_K_OP_FIRST]) |=>
    pos_abort[0] && sync_clear[0]) else $error("no abort on new error");
  a_derr_hold: assert property ((ce && !wr_job_done) |=> $stable(data_error_flag))
    else $error("data error flag moved without write job");
endmodule : dei_buffer_changed_flag_core

// [dei_host.sv]
`timescale 1ns/100ps
// behavioural host controller: apb master that reads the buffer and acks errors
module dei_host (
  input wire logic clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic pready
);
  // idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end

  // one transfer: setup, access, hold until pready seen high at a rising edge
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // the bench timeout bounds this wait
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines show junk so stale values are never trusted
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : dei_host

// [dei_pkg.sv]
package dei_pkg;
  localparam int DEI_DEPTH = 9; // ring entries
  localparam int DEI_NSRC = 16; // 8 sources per channel
  // register byte offsets
  localparam logic [11:0] DEI_OFF_CTRL = 12'h000;
  localparam logic [11:0] DEI_OFF_STAT = 12'h004;
  localparam logic [11:0] DEI_OFF_PEND = 12'h008;
  localparam logic [11:0] DEI_OFF_ENTRY0 = 12'h010;
  // control bits
  localparam int DEI_C_RUN = 0; // host in run
  localparam int DEI_C_IRQEN = 1; // diagnostic interrupts enabled
  localparam int DEI_C_INUSE = 2; // two bits, channels in use
  localparam int DEI_C_ACK = 4; // two bits, travel error acknowledge
  localparam int DEI_C_BCLR = 6; // delete buffer
  localparam int DEI_C_SYSPB = 7; // parameters from system parameter block
  localparam logic [7:0] DEI_CTRL_RST = 8'h0c;
  localparam logic [7:0] DEI_CTRL_WMASK = 8'h8f; // ack and delete are pulses
  // status fields
  localparam int DEI_S_CHG = 0;
  localparam int DEI_S_DERR = 2;
  localparam int DEI_S_TERR = 4;
  localparam int DEI_S_GF = 6;
  localparam int DEI_S_MDF = 7;
  localparam int DEI_S_CNT = 8;
  localparam int DEI_S_CLS = 16;
  // error classes
  localparam logic [7:0] DEI_CLS_OPER = 8'h01;
  localparam logic [7:0] DEI_CLS_MDAT = 8'h05;
  localparam logic [7:0] DEI_CLS_BUFFER_CHANGED_FLAG = 8'h80;
  // interrupt event class codes
  localparam logic [7:0] DEI_EV_LEAVE = 8'h38;
  localparam logic [7:0] DEI_EV_ENTER = 8'h39;
  // source slots within a channel
  localparam int DEI_K_PIN_LAST = 3; // 0..3 pin diagnostics
  localparam int DEI_K_SYNC_LAST = 5; // 0..5 drop synchronization
  localparam int DEI_K_OP_FIRST = 4; // 4..6 operating errors
  localparam int DEI_K_OP_LAST = 6;
  localparam int DEI_K_MD = 7; // machine data error
  // one logged diagnostic event, one bus word
  typedef struct packed {
    logic entering;
    logic internal;
    logic external;
    logic [7:0] eclass;
    logic [7:0] number;
    logic chan;
    logic [7:0] idim;
    logic [3:0] pad;
  } dei_entry_t;
  // synchronous error report from job logic
  typedef struct packed {
    logic [7:0] eclass;
    logic [7:0] number;
    logic chan;
    logic [7:0] idim;
    logic travel; // raised at travel start
  } dei_job_err_t;
endpackage : dei_pkg

// [dei_sync.sv]
`timescale 1ns/100ps
// three-stage pin synchronizer, level accepted when stages two and three agree
module dei_sync #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] level_q
);
  logic [W-1:0] s1_q; // read only by s2
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] level_d;

  // accept per bit only where stages agree, filters a one-cycle glitch
  always_comb begin
    level_d = level_q;
    for (int i = 0; i < W; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        level_d[i] = s3_q[i];
      end
    end
  end

  // shift chain
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      level_q <= '0;
    end else if (ce) begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level_q <= level_d;
    end
  end
endmodule : dei_sync

// [test_dei_buffer_changed_flag_core.sv]
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin error_cnt++; \
  $display("unexpected %s exp %h got %h", nm, ex, gt); end end
// self-checking bench of the diagnostic core, host model drives the register bus
module test_dei_buffer_changed_flag_core;
  typedef struct {logic [31:0] d; logic [31:0] m; logic e; logic chk;} dei_note_t;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1; // ce stays high: freeze is not exercised
  logic psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] buffer_changed_flag_pin = 8'h00, buffer_changed_flag_ev_class;
  logic [5:0] oper_err = 6'h00;
  logic [1:0] md_err = 2'b00, start_cmd = 2'b00, dir_p_cmd = 2'b00, dir_m_cmd = 2'b00;
  logic [1:0] beyond_p = 2'b00, beyond_m = 2'b00, start_ok, dir_p_ok, dir_m_ok;
  logic [1:0] pos_abort, sync_clear, buffer_changed_flag, data_error_flag;
  logic [1:0] travel_start_error_flag, abort_seen = 2'b00, sync_seen = 2'b00;
  logic job_err_valid = 1'b0, wr_job_done = 1'b0, wr_job_chan = 1'b0, wr_job_err = 1'b0;
  logic pos_busy = 1'b0, group_fault_indicator, channel_one_fault_indicator;
  logic channel_two_fault_indicator, buffer_changed_flag_int, module_fault_bit;
  dei_pkg::dei_job_err_t job_err = '0;
  dei_note_t bq[$]; // expected bus answers, oldest first
  logic [7:0] iq[$]; // expected interrupt event classes
  logic [7:0] nums[10];
  logic [31:0] seed = 32'hc3e6;
  int error_cnt = 0, comparisons = 0, cyc = 0;

  dei_host dei_host_i (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready));
  dei_buffer_changed_flag_core dei_buffer_changed_flag_core_i (.clk(clk), .rst(rst), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .buffer_changed_flag_pin(buffer_changed_flag_pin), .oper_err(oper_err),
    .md_err(md_err), .job_err_valid(job_err_valid), .job_err(job_err),
    .wr_job_done(wr_job_done), .wr_job_chan(wr_job_chan), .wr_job_err(wr_job_err),
    .pos_busy(pos_busy), .start_cmd(start_cmd), .dir_p_cmd(dir_p_cmd),
    .dir_m_cmd(dir_m_cmd), .beyond_p(beyond_p), .beyond_m(beyond_m), .start_ok(start_ok),
    .dir_p_ok(dir_p_ok), .dir_m_ok(dir_m_ok), .pos_abort(pos_abort),
    .sync_clear(sync_clear), .group_fault_indicator(group_fault_indicator),
    .channel_one_fault_indicator(channel_one_fault_indicator),
    .channel_two_fault_indicator(channel_two_fault_indicator),
    .buffer_changed_flag(buffer_changed_flag), .data_error_flag(data_error_flag),
    .travel_start_error_flag(travel_start_error_flag), .buffer_changed_flag_int(buffer_changed_flag_int),
    .buffer_changed_flag_ev_class(buffer_changed_flag_ev_class), .module_fault_bit(module_fault_bit));

  // 25 mhz clock
  initial begin
    forever #20 clk = ~clk;
  end

  // galois-free shift register, cheap and repeatable
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  // verdict and end of run
  task automatic end_sim();
    if (error_cnt == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  // read with expected word under a mask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m,
    input logic er);
    bq.push_back('{e, m, er, 1'b1});
    dei_host_i.xfer(1'b0, a, 32'h0);
  endtask : rd

  // write, answer not compared
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bq.push_back('{32'h0, 32'h0, 1'b0, 1'b0});
    dei_host_i.xfer(1'b1, a, d);
  endtask : wr

  // expected entry word of a logged job error
  function automatic logic [31:0] ent(input logic [7:0] n);
    return 32'h80000000 | (32'h04 << 21) | ({24'h0, n} << 13) | 32'h1000;
  endfunction : ent

  // watcher: pairs each answer and interrupt with the oldest note
  always @(posedge clk) begin
    cyc++;
    abort_seen <= abort_seen | pos_abort;
    sync_seen <= sync_seen | sync_clear;
    if (pready === 1'b1 && bq.size() > 0) begin
      dei_note_t n;
      n = bq.pop_front();
      if (n.chk) begin
        `CHK("prdata", n.d, prdata & n.m)
        `CHK("pslverr", n.e, pslverr)
      end
    end
    if (buffer_changed_flag_int === 1'b1) begin
      if (iq.size() == 0) `CHK("buffer_changed_flag_int", 1'b0, buffer_changed_flag_int)
      else `CHK("buffer_changed_flag_ev_class", iq.pop_front(), buffer_changed_flag_ev_class)
    end
    // generous ceiling, the whole sequence needs well under a thousand cycles
    if (cyc == 20000) begin
      error_cnt++;
      end_sim();
    end
  end

  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(dei_pkg::DEI_OFF_CTRL, 32'h0c, 32'hffffffff, 1'b0);
    rd(dei_pkg::DEI_OFF_STAT, 32'h0, 32'hffffffff, 1'b0);
    rd(12'h0ff, 32'h0, 32'hffffffff, 1'b1); // unmapped place answers with an error
    wr(dei_pkg::DEI_OFF_CTRL, 32'h0f);
    // travel range exceeded on channel one while commands are held
    iq.push_back(dei_pkg::DEI_EV_ENTER);
    oper_err <= 6'h01;
    beyond_p <= 2'b01;
    start_cmd <= 2'b11;
    dir_p_cmd <= 2'b11;
    dir_m_cmd <= 2'b11;
    repeat (6) @(posedge clk);
    `CHK("start_ok", 2'b10, start_ok)
    `CHK("dir_p_ok", 2'b10, dir_p_ok)
    `CHK("dir_m_ok", 2'b11, dir_m_ok)
    `CHK("abort_seen", 2'b01, abort_seen)
    `CHK("sync_seen", 2'b01, sync_seen)
    `CHK("group_fault", 1'b1, group_fault_indicator)
    `CHK("ch_one_fault", 1'b1, channel_one_fault_indicator)
    `CHK("module_fault", 1'b1, module_fault_bit)
    `CHK("changed", 2'b11, buffer_changed_flag)
    rd(dei_pkg::DEI_OFF_STAT, 32'h103, 32'hf03, 1'b0);
    rd(dei_pkg::DEI_OFF_ENTRY0, 32'h80200000, 32'h9fe01000, 1'b0);
    repeat (2) @(posedge clk);
    `CHK("changed", 2'b00, buffer_changed_flag)
    // last error leaves
    iq.push_back(dei_pkg::DEI_EV_LEAVE);
    oper_err <= 6'h00;
    repeat (4) @(posedge clk);
    `CHK("group_fault", 1'b0, group_fault_indicator)
    `CHK("module_fault", 1'b0, module_fault_bit)
    rd(dei_pkg::DEI_OFF_STAT, 32'h100, 32'hf03, 1'b0);
    // error arrives in stop, shows up at run
    // a channel two fault that keeps synchronization
    wr(dei_pkg::DEI_OFF_CTRL, 32'h0e);
    oper_err <= 6'h20;
    repeat (4) @(posedge clk);
    `CHK("ch_two_fault", 1'b1, channel_two_fault_indicator)
    `CHK("sync_seen", 2'b01, sync_seen)
    iq.push_back(dei_pkg::DEI_EV_ENTER);
    wr(dei_pkg::DEI_OFF_CTRL, 32'h0f);
    repeat (4) @(posedge clk);
    // cleared in stop, silent at run
    wr(dei_pkg::DEI_OFF_CTRL, 32'h0e);
    oper_err <= 6'h00;
    repeat (4) @(posedge clk);
    wr(dei_pkg::DEI_OFF_CTRL, 32'h0f);
    repeat (6) @(posedge clk);
    // machine data and pin error overlap, partial clear re-enters
    wr(dei_pkg::DEI_OFF_CTRL, 32'h8f);
    iq.push_back(dei_pkg::DEI_EV_ENTER);
    md_err <= 2'b01;
    repeat (4) @(posedge clk);
    iq.push_back(dei_pkg::DEI_EV_ENTER);
    buffer_changed_flag_pin <= 8'h10;
    repeat (8) @(posedge clk);
    `CHK("sync_seen", 2'b11, sync_seen)
    iq.push_back(dei_pkg::DEI_EV_ENTER);
    md_err <= 2'b00;
    repeat (4) @(posedge clk);
    iq.push_back(dei_pkg::DEI_EV_LEAVE);
    buffer_changed_flag_pin <= 8'h00;
    repeat (8) @(posedge clk);
    // delete refused while positioning runs: four entering events, no leaving ones
    pos_busy <= 1'b1;
    wr(dei_pkg::DEI_OFF_CTRL, 32'h4f);
    rd(dei_pkg::DEI_OFF_STAT, 32'h400, 32'hf00, 1'b0);
    pos_busy <= 1'b0;
    // empty the buffer, then log ten job errors to wrap it
    wr(dei_pkg::DEI_OFF_CTRL, 32'h4f);
    rd(dei_pkg::DEI_OFF_STAT, 32'h0, 32'hf00, 1'b0);
    for (int i = 0; i < 10; i++) begin
      seed = lfsr_next(seed);
      nums[i] = seed[7:0];
      @(posedge clk);
      job_err_valid <= 1'b1;
      job_err <= '{8'h04, seed[7:0], 1'b1, 8'h00, i == 9};
      @(posedge clk);
      job_err_valid <= 1'b0;
    end
    repeat (2) @(posedge clk);
    rd(dei_pkg::DEI_OFF_STAT, 32'h903, 32'hf03, 1'b0);
    rd(dei_pkg::DEI_OFF_ENTRY0, ent(nums[1]), 32'h9ffff000, 1'b0);
    rd(12'h030, ent(nums[9]), 32'h9ffff000, 1'b0);
    `CHK("travel_err", 2'b10, travel_start_error_flag)
    wr(dei_pkg::DEI_OFF_CTRL, 32'h2f);
    repeat (2) @(posedge clk);
    `CHK("travel_err", 2'b00, travel_start_error_flag)
    // data error flag holds until the next write job
    wr_job_done <= 1'b1;
    wr_job_err <= 1'b1;
    @(posedge clk);
    wr_job_done <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK("data_err", 2'b01, data_error_flag)
    wr_job_done <= 1'b1;
    wr_job_err <= 1'b0;
    @(posedge clk);
    wr_job_done <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK("data_err", 2'b00, data_error_flag)
    `CHK("notes_left", 0, bq.size() + iq.size())
    end_sim();
  end
endmodule : test_dei_buffer_changed_flag_core
